// ### design/measurement_cycle_sequencer.sv
// Module: measurement cycle sequencer and converter control
// ==========================================================
// Contract
// - The mux select walks temperature, channel offset and bridge inputs.
// - Bridge count per slot is configurable from 1 to 31.
// - A start routine takes all measurements before the normal cycle.
// - Normal cycle is six slots, each followed by n bridge measurements.
// - Common-mode and both short checks run every cycle regardless.
// - Resolution is 13 or 14 bits, or 15 or 16 with segmentation.
// - First-order and stacked second-order modes are selectable.
// - First-order conversion lasts 2^res half-oscillator periods.
// - Second-order conversion lasts 2^((res+3)/2) half-oscillator periods.
// - Count is 2^res times (input ratio plus range shift).
// - Range shift is one of 1/16, 1/8, 1/4 or 1/2.
// - Reference is bridge top-bottom unless supply select bit is one.
// - No check is made that the input lies within 10% to 90% of range.
// - Temperature slot uses one of four selected sources.
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module measurement_cycle_sequencer #(
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Analogue front end
	input  wire logic [15:0] ratio_i,
	output logic      [1:0]  mux_sel_o,
	output logic      [2:0]  diag_sel_o,
	output logic      [1:0]  temp_src_o,
	output logic             ref_supply_o,
	output logic             conv_busy_o,
	// Result stream to correction_processor
	output logic             res_valid_o,
	input  wire logic        res_ready_i,
	output logic      [2:0]  res_tag_o,
	output logic      [17:0] res_count_o,
	output logic             start_done_o
);
	// ==========================================================
	// Registers
	logic [31:0]       cfg_r;
	logic [31:0]       last_r;
	seq_pkg::state_e   st_r;
	seq_pkg::slot_e    slot_r;
	logic [4:0]        brg_r;
	logic [2:0]        idx_r;
	logic              bridge_r;
	logic              start_r;
	logic [16:0]       tick_r;
	logic [16:0]       len;
	logic [4:0]        n_cfg;
	logic [4:0]        res;
	logic [17:0]       shift;
	logic [17:0]       count;
	logic [2:0]        tag;
	logic              f_ready;
	logic              f_valid;
	logic              push;
	logic              div_en;
	logic [7:0]        div_r;
	seq_pkg::result_s  f_in;
	seq_pkg::result_s  f_out;
	initial begin
		if (FIFO_DEPTH < 2)
			$error("FIFO_DEPTH too small");
	end
	// Config fields; n below one is forced to one
	assign n_cfg = (cfg_r[seq_pkg::CFG_N_LSB +: 5] < seq_pkg::N_MIN) ?
		seq_pkg::N_MIN : cfg_r[seq_pkg::CFG_N_LSB +: 5];
	assign res = 5'd13 + {3'h0, cfg_r[seq_pkg::CFG_RES_LSB +: 2]};
	// Conversion length in half-oscillator ticks
	always_comb begin
		if (cfg_r[seq_pkg::CFG_ORD_BIT])
			len = 17'h1 << ((res + 5'd3) >> 1);
		else
			len = 17'h1 << res;
	end
	// Range shift 2^res >> (4 - code); no limit check on input
	assign shift = 18'h1 << (res - 5'd4 +
		{3'h0, cfg_r[seq_pkg::CFG_RS_LSB +: 2]});
	// Count = 2^res*ratio (ratio Q16) + shift; product held wide so the
	// top bits of the ratio are not lost before the scale-down
	assign count = 18'((34'(ratio_i) << res) >> 16) + shift;
	// ==========================================================
	// Half-oscillator tick enable
	assign div_en = div_r == 8'(seq_pkg::CONV_DIV - 1);
	always_ff @(posedge clk_i) begin
		if (rst_i || div_en)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end
	// ==========================================================
	// Slot tag encoding
	always_comb begin
		unique case (slot_r)
			seq_pkg::SL_TAZ: tag = 3'h0;
			seq_pkg::SL_TMP: tag = 3'h1;
			seq_pkg::SL_BAZ: tag = 3'h2;
			seq_pkg::SL_CMC: tag = 3'h3;
			seq_pkg::SL_SCP: tag = 3'h4;
			seq_pkg::SL_SCN: tag = 3'h5;
			default:         tag = 3'h6;
		endcase
	end
	// Mux steering: 0 temp, 1 offset, 2 bridge, 3 diagnostic
	always_comb begin
		diag_sel_o = 3'h0;
		unique case (slot_r)
			seq_pkg::SL_TAZ, seq_pkg::SL_BAZ: mux_sel_o = 2'h1;
			seq_pkg::SL_TMP: mux_sel_o = 2'h0;
			seq_pkg::SL_BRG: mux_sel_o = 2'h2;
			default: begin
				mux_sel_o  = 2'h3;
				diag_sel_o = tag;
			end
		endcase
	end
	assign temp_src_o   = cfg_r[seq_pkg::CFG_TSRC_LSB +: 2];
	assign ref_supply_o = cfg_r[seq_pkg::CFG_REF_BIT];
	assign conv_busy_o  = st_r == seq_pkg::ST_CONV;
	assign start_done_o = start_r;
	// ==========================================================
	// Slot sequencer; a conversion only ends when FIFO has room
	assign push = st_r == seq_pkg::ST_CONV && tick_r == len && f_ready;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r     <= seq_pkg::ST_IDLE;
			slot_r   <= seq_pkg::SL_TAZ;
			idx_r    <= '0;
			brg_r    <= '0;
			bridge_r <= 1'b0;
			start_r  <= 1'b0;
			tick_r   <= '0;
		end else begin
			unique case (st_r)
				seq_pkg::ST_IDLE: begin
					if (cfg_r[seq_pkg::CFG_RUN_BIT]) begin
						st_r   <= seq_pkg::ST_CONV;
						tick_r <= '0;
					end
				end
				seq_pkg::ST_START, seq_pkg::ST_CONV: begin
					if (push)
						st_r <= seq_pkg::ST_NEXT;
					else if (div_en && tick_r != len)
						tick_r <= tick_r + 1'b1;
				end
				seq_pkg::ST_NEXT: begin
					tick_r <= '0;
					st_r   <= seq_pkg::ST_CONV;
					if (!start_r) begin
						// Start routine: six slots then one bridge
						if (slot_r == seq_pkg::SL_BRG) begin
							start_r <= 1'b1;
							slot_r  <= seq_pkg::SL_TAZ;
							idx_r   <= '0;
						end else if (idx_r == 3'(seq_pkg::START_SLOTS - 1))
							slot_r <= seq_pkg::SL_BRG;
						else begin
							idx_r  <= idx_r + 1'b1;
							slot_r <= seq_pkg::slot_e'(8'h1 << (idx_r + 3'h1));
						end
					end else if (!bridge_r) begin
						bridge_r <= 1'b1;
						brg_r    <= 5'h1;
						slot_r   <= seq_pkg::SL_BRG;
					end else if (brg_r < n_cfg) begin
						brg_r <= brg_r + 1'b1;
					end else begin
						bridge_r <= 1'b0;
						idx_r    <= (idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1;
						slot_r   <= seq_pkg::slot_e'(8'h1 <<
							((idx_r == 3'h5) ? 3'h0 : idx_r + 3'h1));
					end
				end
				default: st_r <= seq_pkg::ST_IDLE;
			endcase
		end
	end
	// ==========================================================
	// Result buffer towards the correction processor
	assign f_in.tag   = tag;
	assign f_in.count = count;
	seq_fifo #(
		.WIDTH (seq_pkg::RES_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push),
		.in_ready_o  (f_ready),
		.in_data_i   (f_in),
		.out_valid_o (f_valid),
		.out_ready_i (res_ready_i),
		.out_data_o  (f_out)
	);
	assign res_valid_o = f_valid;
	assign res_tag_o   = f_out.tag;
	assign res_count_o = f_out.count;
	// Last result seen, for software
	always_ff @(posedge clk_i) begin
		if (rst_i)
			last_r <= '0;
		else if (push)
			last_r <= {11'h0, f_in};
	end
	// ==========================================================
	// Wishbone slave: one wait cycle, ack drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i && stb_i && !ack_o;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_r <= seq_pkg::CFG_RESET;
		else if (cyc_i && stb_i && we_i && !ack_o
			&& adr_i == seq_pkg::CFG_OFF) begin
			for (int b = 0; b < 4; b++)
				if (sel_i[b])
					cfg_r[b*8 +: 8] <= dat_i[b*8 +: 8];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= '0;
		else if (cyc_i && stb_i && !ack_o) begin
			unique case (adr_i)
				seq_pkg::CFG_OFF:    dat_o <= cfg_r;
				seq_pkg::STATUS_OFF: dat_o <= {21'h0, tag, 3'h0,
					start_r, f_valid, f_ready, conv_busy_o, st_r == seq_pkg::ST_IDLE};
				seq_pkg::RESULT_OFF: dat_o <= last_r;
				seq_pkg::FIFO_OFF:   dat_o <= {29'h0, 3'(FIFO_DEPTH > 0)};
				default:             dat_o <= '0;
			endcase
		end
	end
	// ==========================================================
	// Checks
	bridge_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bridge_r |-> brg_r >= 5'h1 && brg_r <= n_cfg)
		else $error("bridge count out of range");
	conv_length_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r == seq_pkg::ST_CONV && div_en && tick_r != len |=>
		tick_r == $past(tick_r) + 17'h1)
		else $error("conversion tick not counted");
	order_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!cfg_r[seq_pkg::CFG_ORD_BIT] |-> len == (17'h1 << res))
		else $error("first order length wrong");
	second_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cfg_r[seq_pkg::CFG_ORD_BIT] |-> len < (17'h1 << res))
		else $error("second order not shorter");
	mux_bridge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		slot_r == seq_pkg::SL_BRG |-> mux_sel_o == 2'h2)
		else $error("bridge slot not on bridge input");
	ref_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ref_supply_o == cfg_r[seq_pkg::CFG_REF_BIT])
		else $error("reference select mismatch");
	push_next_a: assert property (@(posedge clk_i) disable iff (rst_i)
		push |=> st_r == seq_pkg::ST_NEXT ##1 st_r == seq_pkg::ST_CONV)
		else $error("slot did not advance");
	diag_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
		start_r && st_r == seq_pkg::ST_NEXT && !bridge_r |=>
		slot_r == seq_pkg::SL_BRG)
		else $error("slot not followed by bridge");
	start_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		start_r |=> start_r)
		else $error("start routine reentered");
endmodule

// ### design/seq_pkg.sv
// Package: constants, types and register map of the measurement sequencer
package seq_pkg;
	// ==========================================================
	// Register map (word aligned byte offsets)
	localparam logic [7:0] CFG_OFF    = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] RESULT_OFF = 8'h08;
	localparam logic [7:0] FIFO_OFF   = 8'h0C;
	// Config field positions
	localparam int CFG_N_LSB     = 0;  // 5 bits bridge count
	localparam int CFG_RES_LSB   = 8;  // 2 bits resolution code
	localparam int CFG_ORD_BIT   = 10; // 1 = second order
	localparam int CFG_RS_LSB    = 12; // 2 bits range shift
	localparam int CFG_REF_BIT   = 14; // supply_reference_select
	localparam int CFG_TSRC_LSB  = 16; // 2 bits temperature source
	localparam int CFG_RUN_BIT   = 20; // start sequencing
	localparam logic [31:0] CFG_RESET = 32'h0000_0001;
	localparam logic [4:0] N_MIN = 5'h01;
	// ==========================================================
	// Timing: converter clock is half the oscillator frequency
	localparam int CLK_HZ   = 25_000_000;
	localparam int OSC_HZ   = 25_000_000;
	localparam int CONV_DIV = (CLK_HZ * 2) / OSC_HZ; // clk per conv tick
	localparam int START_SLOTS = 6;
	// ==========================================================
	typedef enum logic [7:0] {
		SL_TAZ  = 8'h01, SL_TMP = 8'h02, SL_BAZ = 8'h04,
		SL_CMC  = 8'h08, SL_SCP = 8'h10, SL_SCN = 8'h20,
		SL_BRG  = 8'h40
	} slot_e;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1, ST_START = 4'h2, ST_CONV = 4'h4, ST_NEXT = 4'h8
	} state_e;
	typedef struct packed {
		logic [2:0]  tag;
		logic [17:0] count;
	} result_s;
	localparam int RES_W = 21;
endpackage

// ### design/seq_fifo.sv
// Module: parameterised valid/ready FIFO
`timescale 1ns/1ps
module seq_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_r;
	logic [AW:0]      rd_r;
	logic             push;
	logic             pop;
	// Honest full and empty from extended pointers
	assign in_ready_o  = (wr_r - rd_r) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_r != rd_r;
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rd_r[AW-1:0]];
	// Storage
	always_ff @(posedge clk_i) begin
		if (push)
			mem[wr_r[AW-1:0]] <= in_data_i;
	end
	// Pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
		end
	end
endmodule

// ### testbench/result_sink.sv
// Far-side model: correction processor and converter input source
`timescale 1ns/1ps
module result_sink #(
	parameter logic [15:0] RATIO = 16'h8000
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Stall request from the bench
	input  wire logic        stall_i,
	// Result stream and converter level
	output logic             ready_o,
	output logic      [15:0] ratio_o
);
	// ==========================================================
	// Converter input
	// A steady ratio keeps every count exactly predictable
	assign ratio_o = RATIO;
	// ==========================================================
	// Consumer
	// Ready is registered, so a stall is seen one edge late, like the real
	// processor that finishes its current word before backing off
	always_ff @(posedge clk_i) begin
		ready_o <= !rst_i && !stall_i;
	end
endmodule

// ### testbench/tb_measurement_cycle_sequencer.sv
// Testbench of the measurement cycle sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb_measurement_cycle_sequencer;
	localparam logic [15:0] RATIO = 16'h8000;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic        stall;
	logic        ready;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack_o;
	logic [15:0] ratio;
	logic [1:0]  mux_sel;
	logic [2:0]  diag_sel;
	logic [1:0]  temp_src;
	logic        ref_supply;
	logic        res_valid_o;
	logic [2:0]  res_tag_o;
	logic [17:0] res_count_o;
	logic        start_done_o;
	int          num_errors;
	int          n_compared;

	measurement_cycle_sequencer measurement_cycle_sequencer_i (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .ratio_i(ratio),
		.mux_sel_o(mux_sel), .diag_sel_o(diag_sel),
		.temp_src_o(temp_src), .ref_supply_o(ref_supply),
		.conv_busy_o(), .res_valid_o(res_valid_o), .res_ready_i(ready),
		.res_tag_o(res_tag_o), .res_count_o(res_count_o),
		.start_done_o(start_done_o));
	result_sink #(.RATIO(RATIO)) result_sink_i (
		.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
		.ready_o(ready), .ratio_o(ratio));

	// ==========================================================
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ==========================================================
	// Shared tasks
	task automatic conclude();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Classic single Wishbone cycle; the request holds until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
			input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 100);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (k >= 100) begin
			num_errors++;
			conclude();
		end
	endtask

	// Waits for the next accepted result; also returns the cycles waited
	task automatic next_res(output logic [2:0] tg, output logic [17:0] ct,
			output int w);
		w = 0;
		do begin
			@(posedge clk_i);
			w++;
		end while (!(res_valid_o === 1'b1 && ready === 1'b1) && w < 20000);
		if (w >= 20000) begin
			num_errors++;
			conclude();
		end
		tg = res_tag_o;
		ct = res_count_o;
	endtask

	// Expected count for a 13 bit conversion with range shift code rs
	function automatic logic [17:0] exp_cnt(input int rs);
		return 18'((int'(RATIO) * 8192) >> 16) + 18'(8192 >> (4 - rs));
	endfunction

	// ==========================================================
	// Scenarios
	task automatic regs_check();
		wb(1'b0, seq_pkg::CFG_OFF, 4'hF, 32'h0, rd);
		`CHK("cfg reset", seq_pkg::CFG_RESET, rd)
		wb(1'b0, 8'h10, 4'hF, 32'h0, rd);
		`CHK("unmapped", 32'h0, rd)
		wb(1'b1, seq_pkg::RESULT_OFF, 4'hF, 32'hFFFF_FFFF, rd);
		wb(1'b0, seq_pkg::RESULT_OFF, 4'hF, 32'h0, rd);
		`CHK("result ro", 32'h0, rd)
		`CHK("no start", 1'b0, start_done_o)
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, seq_pkg::CFG_OFF, 4'hF, (i << 16) | ((i & 1) << 14), rd);
			`CHK("temp src", 2'(i), temp_src)
			`CHK("ref sel", 1'(i & 1), ref_supply)
		end
		// Low lane only: n goes to its top value 31
		wb(1'b1, seq_pkg::CFG_OFF, 4'h1, 32'hFFFF_FF1F, rd);
		wb(1'b0, seq_pkg::CFG_OFF, 4'hF, 32'h0, rd);
		`CHK("cfg lane", 32'h0003_401F, rd)
	endtask

	// Start routine then normal cycle with n=2, second order, shift 1/2;
	// the consumer stalls first so the buffer fills and refuses
	task automatic sequence_check();
		logic [2:0]  tg;
		logic [17:0] ct;
		logic [2:0]  et;
		int          w;
		stall <= 1'b1;
		wb(1'b1, seq_pkg::CFG_OFF, 4'hF, 32'h0010_3402, rd);
		repeat (6000) @(posedge clk_i);
		wb(1'b0, seq_pkg::STATUS_OFF, 4'hF, 32'h0, rd);
		`CHK("fifo full", 2'b10, rd[3:2])
		`CHK("stuck tag", 3'h6, rd[10:8])
		`CHK("mux bridge", 2'h2, mux_sel)
		`CHK("diag off", 3'h0, diag_sel)
		stall <= 1'b0;
		for (int k = 0; k < 25; k++) begin
			next_res(tg, ct, w);
			et = (k < 7) ? 3'(k) : ((k - 7) % 3 == 0) ? 3'((k - 7) / 3) : 3'h6;
			`CHK("slot tag", et, tg)
			`CHK("count", exp_cnt(3), ct)
			if (k == 8) `CHK("start done", 1'b1, start_done_o)
		end
	endtask

	// First order, shift 1/16: a full conversion lasts 2^13 converter ticks
	task automatic first_order_check();
		logic [2:0]  tg;
		logic [17:0] ct;
		int          w;
		int          len;
		wb(1'b1, seq_pkg::CFG_OFF, 4'hF, 32'h0010_0001, rd);
		for (int k = 0; k < 3; k++) begin
			next_res(tg, ct, w);
		end
		len = 8192 * seq_pkg::CONV_DIV;
		`CHK("conv len", 1'b1, (w >= len && w <= len + 16))
		`CHK("count 1st", exp_cnt(0), ct)
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		num_errors = 0;
		n_compared = 0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i  = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		stall = 1'b0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		regs_check();
		sequence_check();
		first_order_check();
		conclude();
	end
endmodule
